//--- design/fsp_pkg.sv
package fsp_pkg;

    // array geometry: 64KB blocks, 4KB sectors in the outer two blocks
    localparam int ADDR_W        = 24;
    localparam int BLOCK_W       = 7;
    localparam int SECTOR_W      = 4;
    localparam int BLOCK_LSB     = 16;
    localparam int SECTOR_LSB    = 12;
    localparam int UNIT_W        = 8;
    localparam int SECTOR_UNITS  = 16;
    localparam int UNITS         = 158;
    localparam logic [BLOCK_W-1:0] BOTTOM_BLOCK = 7'h00;
    localparam logic [BLOCK_W-1:0] TOP_BLOCK    = 7'h7F;
    localparam logic [UNIT_W-1:0]  TOP_SECTOR_BASE   = 8'h10;
    localparam logic [UNIT_W-1:0]  MIDDLE_BLOCK_BASE = 8'h1F;

    // opcodes printed for this block
    localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_READ_SECURITY   = 8'h2B;
    localparam logic [7:0] OP_WRITE_SECURITY  = 8'h2F;
    localparam logic [7:0] OP_SCHEME_SELECT   = 8'h68;
    localparam logic [7:0] OP_SOLID_READ      = 8'hE2;
    localparam logic [7:0] OP_DYNAMIC_READ    = 8'hE0;
    localparam logic [7:0] OP_ALL_LOCK        = 8'h7E;
    localparam logic [7:0] OP_ALL_UNLOCK      = 8'h98;

    // security_status_register field positions
    localparam int SEC_FACTORY_LOCK = 0;
    localparam int SEC_OTP_LOCKDOWN = 1;
    localparam int SEC_PROG_SUSP    = 2;
    localparam int SEC_ERASE_SUSP   = 3;
    localparam int SEC_RESERVED     = 4;
    localparam int SEC_PROG_FAIL    = 5;
    localparam int SEC_ERASE_FAIL   = 6;
    localparam int SEC_SCHEME       = 7;

    // frame lengths in serial clocks
    localparam logic [5:0] BITS_OPCODE    = 6'd8;
    localparam logic [5:0] BITS_ADDR      = 6'd32;
    localparam logic [5:0] BITS_ADDR_DATA = 6'd40;
    localparam logic [5:0] BITS_MAX       = 6'd63;

    localparam logic [7:0] BYTE_PROTECTED   = 8'hFF;
    localparam logic [7:0] BYTE_UNPROTECTED = 8'h00;

    // reset values
    localparam logic DYNAMIC_RESET  = 1'b1;
    localparam logic OVERRIDE_RESET = 1'b1;
    localparam logic NV_FACTORY     = 1'b0;

    typedef struct packed {
        logic progSuspend;
        logic progResume;
        logic eraseSuspend;
        logic eraseResume;
        logic progDone;
        logic progFail;
        logic eraseDone;
        logic eraseFail;
    } fsp_events_s;

endpackage

//--- design/fsp_security.sv
// Functional notes
// (R1) security read accepted anytime, repeatable
// (R2) select, opcode, byte out, deselect; upper ignored
// (R3) bit0 read-only factory lock indicator
// (R4) lockdown bit set once, then frozen
// (R5) bit2 program suspended, cleared on resume
// (R6) bit3 erase suspended, cleared on resume
// (R7) bit5 program fail sticky until good program
// (R8) bit6 erase fail sticky until good erase
// (R9) bit7 selects block or sector scheme
// (R10) host sets write latch before security write
// (R11) write commands need deselect on byte boundary
// (R12) scheme select needs latch, never reverts
// (R13) block protect level only in block mode
// (R14) sector commands only in sector mode; solid read is also accepted in block mode
// (R15) write protect pin low protects everything; applied only in sector mode
// (R16) per-sector bits outer blocks, per-block elsewhere
// (R17) solid or dynamic bit inhibits program/erase
// (R18) solid bits set singly, erased together
// (R19) host sets latch before solid commands
// (R20) solid read returns 00h or FFh
// (R21) sector mode starts all dynamically protected
// (R22) clearing override masks solid bits
// (R23) dynamic bits volatile, reset one, latch-gated
// (R24) override volatile, resets one, masks solid
// (R25) byte out MSB first on falling edges
module fsp_security
    import fsp_pkg::*;
#(
    parameter logic [7:0] OP_SOLID_PROGRAM = 8'hE3,
    parameter logic [7:0] OP_SOLID_ERASE   = 8'hE4,
    parameter logic [7:0] OP_DYNAMIC_WRITE = 8'hE1
) (
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    input  wire logic                 chipSelectN,
    input  wire logic                 serialClk,
    input  wire logic                 serialIn,
    input  wire logic                 writeProtectN,
    input  wire logic                 factoryLockIn,
    input  wire fsp_pkg::fsp_events_s coreEvents,
    input  wire logic                 overrideWrite,
    input  wire logic                 overrideValue,
    input  wire logic [3:0]           blockProtectLevel,
    input  wire logic                 bpAreaHit,
    input  wire logic [ADDR_W-1:0]    queryAddr,
    output logic                      serialOut,
    output logic                      serialOutEn,
    output logic                      writeLatch,
    output logic                      protectionScheme,
    output logic                      otpLockdown,
    output logic                      queryProtected,
    output logic [7:0]                securityStatus
);
    import fsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [UNIT_W-1:0] unitIndex(
        input logic [ADDR_W-1:0] a
    );
        logic [BLOCK_W-1:0]  blk;
        logic [SECTOR_W-1:0] sec;
        blk = a[BLOCK_LSB +: BLOCK_W];
        sec = a[SECTOR_LSB +: SECTOR_W];
        if (blk == BOTTOM_BLOCK) begin // R16
            unitIndex = {{(UNIT_W-SECTOR_W){1'b0}}, sec};
        end else if (blk == TOP_BLOCK) begin
            unitIndex = TOP_SECTOR_BASE + {{(UNIT_W-SECTOR_W){1'b0}}, sec};
        end else begin
            unitIndex = MIDDLE_BLOCK_BASE + {1'b0, blk};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers

    logic [1:0] rstPipe;
    logic       rstN;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstN = rstPipe[1];

    logic csS1, csS2, csPrev;
    logic sckS1, sckS2, sckPrev;
    logic sioS1, sioS2;
    logic wpS1, wpS2;

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            csS1    <= 1'b1;
            csS2    <= 1'b1;
            csPrev  <= 1'b1;
            sckS1   <= 1'b0;
            sckS2   <= 1'b0;
            sckPrev <= 1'b0;
            sioS1   <= 1'b0;
            sioS2   <= 1'b0;
            wpS1    <= 1'b1;
            wpS2    <= 1'b1;
        end else begin
            csS1    <= chipSelectN;
            csS2    <= csS1;
            csPrev  <= csS2;
            sckS1   <= serialClk;
            sckS2   <= sckS1;
            sckPrev <= sckS2;
            sioS1   <= serialIn;
            sioS2   <= sioS1;
            wpS1    <= writeProtectN;
            wpS2    <= wpS1;
        end
    end

    logic sckRise, sckFall, csRise;
    assign sckRise = sckS2 & ~sckPrev & ~csS2;
    assign sckFall = ~sckS2 & sckPrev & ~csS2;
    assign csRise  = csS2 & ~csPrev;

    ////////////////////////////////////////////////////////////////////////
    // serial receive

    logic [5:0]        bitCnt;
    logic [31:0]       rxShift;
    logic [7:0]        opcode;
    logic [ADDR_W-1:0] cmdAddr;
    logic [7:0]        dataByte;
    logic [7:0]        next_opcode;
    logic [ADDR_W-1:0] next_addr;

    assign next_opcode = {rxShift[6:0], sioS2};
    assign next_addr   = {rxShift[ADDR_W-2:0], sioS2};

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            bitCnt   <= 6'd0;
            rxShift  <= 32'h0000_0000;
            opcode   <= 8'h00;
            cmdAddr  <= '0;
            dataByte <= 8'h00;
        end else if (csS2) begin
            bitCnt <= 6'd0;
        end else if (sckRise) begin
            rxShift <= {rxShift[30:0], sioS2};
            if (bitCnt != BITS_MAX) begin
                bitCnt <= bitCnt + 6'd1;
            end
            if (bitCnt == BITS_OPCODE - 6'd1) begin
                opcode <= next_opcode;
            end
            if (bitCnt == BITS_ADDR - 6'd1) begin
                cmdAddr <= next_addr;
            end
            if (bitCnt == BITS_ADDR_DATA - 6'd1) begin
                dataByte <= next_opcode;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command execution on deselect

    logic protection_scheme_select;
    logic endOn8, endOn32, endOn40;
    logic sectorOk;
    logic execLatch, execSecWrite, execScheme;
    logic execSolidProg, execSolidErase, execDynWrite;
    logic execAllLock, execAllUnlock, execAnyWrite;

    assign endOn8  = csRise && (bitCnt == BITS_OPCODE); // R11
    assign endOn32 = csRise && (bitCnt == BITS_ADDR); // R11
    assign endOn40 = csRise && (bitCnt == BITS_ADDR_DATA); // R11
    assign sectorOk = writeLatch && protection_scheme_select; // R14 R19

    assign execLatch      = endOn8 && (opcode == OP_WRITE_LATCH_SET);
    assign execSecWrite   = endOn8 && (opcode == OP_WRITE_SECURITY)
                            && writeLatch; // R10
    assign execScheme     = endOn8 && (opcode == OP_SCHEME_SELECT)
                            && writeLatch; // R12
    assign execSolidProg  = endOn32 && (opcode == OP_SOLID_PROGRAM)
                            && sectorOk;
    assign execSolidErase = endOn8 && (opcode == OP_SOLID_ERASE)
                            && sectorOk;
    assign execDynWrite   = endOn40 && (opcode == OP_DYNAMIC_WRITE)
                            && sectorOk; // R23
    assign execAllLock    = endOn8 && (opcode == OP_ALL_LOCK)
                            && sectorOk; // R23
    assign execAllUnlock  = endOn8 && (opcode == OP_ALL_UNLOCK)
                            && sectorOk; // R23
    assign execAnyWrite   = execSecWrite | execScheme | execSolidProg
                            | execSolidErase | execDynWrite
                            | execAllLock | execAllUnlock;

    // write latch: set by its command, spent by any accepted write
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            writeLatch <= 1'b0;
        end else if (execLatch) begin
            writeLatch <= 1'b1;
        end else if (execAnyWrite) begin
            writeLatch <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // security status bits

    logic factoryLock;
    logic progSusp, eraseSusp, progFailFlag, eraseFailFlag;
    logic [7:0] secReg;

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            factoryLock <= NV_FACTORY;
        end else begin
            factoryLock <= factoryLockIn; // R3
        end
    end

    // non-volatile lock bits modelled as factory state at reset
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            otpLockdown <= NV_FACTORY;
        end else if (execSecWrite) begin
            otpLockdown <= 1'b1; // R4
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            protection_scheme_select <= NV_FACTORY;
        end else if (execScheme) begin
            protection_scheme_select <= 1'b1; // R9 R12
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            progSusp  <= 1'b0;
            eraseSusp <= 1'b0;
        end else begin
            if (coreEvents.progSuspend) begin
                progSusp <= 1'b1; // R5
            end else if (coreEvents.progResume) begin
                progSusp <= 1'b0; // R5
            end
            if (coreEvents.eraseSuspend) begin
                eraseSusp <= 1'b1; // R6
            end else if (coreEvents.eraseResume) begin
                eraseSusp <= 1'b0; // R6
            end
        end
    end

    // a failure in the same cycle as a success keeps the flag set
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            progFailFlag  <= 1'b0;
            eraseFailFlag <= 1'b0;
        end else begin
            if (coreEvents.progFail) begin
                progFailFlag <= 1'b1; // R7
            end else if (coreEvents.progDone) begin
                progFailFlag <= 1'b0; // R7
            end
            if (coreEvents.eraseFail) begin
                eraseFailFlag <= 1'b1; // R8
            end else if (coreEvents.eraseDone) begin
                eraseFailFlag <= 1'b0; // R8
            end
        end
    end

    always_comb begin
        secReg                   = 8'h00;
        secReg[SEC_FACTORY_LOCK] = factoryLock;
        secReg[SEC_OTP_LOCKDOWN] = otpLockdown;
        secReg[SEC_PROG_SUSP]    = progSusp;
        secReg[SEC_ERASE_SUSP]   = eraseSusp;
        secReg[SEC_RESERVED]     = 1'b0;
        secReg[SEC_PROG_FAIL]    = progFailFlag;
        secReg[SEC_ERASE_FAIL]   = eraseFailFlag;
        secReg[SEC_SCHEME]       = protection_scheme_select;
    end

    assign securityStatus   = secReg;
    assign protectionScheme = protection_scheme_select;

    ////////////////////////////////////////////////////////////////////////
    // protection bit arrays

    logic [UNITS-1:0] solidBits;
    logic [UNITS-1:0] dynamicBits;
    logic             solidOverride;

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            solidBits <= {UNITS{NV_FACTORY}}; // R18
        end else if (execSolidErase) begin
            solidBits <= '0; // R18
        end else if (execSolidProg) begin
            solidBits[unitIndex(cmdAddr)] <= 1'b1; // R18
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            dynamicBits <= {UNITS{DYNAMIC_RESET}}; // R21 R23
        end else if (execAllLock) begin
            dynamicBits <= {UNITS{1'b1}}; // R23
        end else if (execAllUnlock) begin
            dynamicBits <= '0; // R23
        end else if (execDynWrite) begin
            dynamicBits[unitIndex(cmdAddr)] <= |dataByte; // R23
        end
    end

    // override source is the password and sequence logic elsewhere
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            solidOverride <= OVERRIDE_RESET; // R24
        end else if (overrideWrite && protection_scheme_select) begin
            solidOverride <= overrideValue; // R22 R24
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protection query for the program and erase engine

    logic [UNIT_W-1:0] queryUnit;
    logic              sectorProt;
    logic              blockProt;

    assign queryUnit  = unitIndex(queryAddr);
    assign sectorProt = ~wpS2 // R15
                        | dynamicBits[queryUnit] // R17
                        | (solidBits[queryUnit] & solidOverride); // R22
    assign blockProt  = (blockProtectLevel != 4'h0) && bpAreaHit;

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            queryProtected <= 1'b1;
        end else begin
            queryProtected <= protection_scheme_select ? sectorProt : blockProt; // R9 R13
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial transmit

    logic [7:0] txByte;
    logic [2:0] txBit;
    logic       txOn;
    logic       txRefresh;
    logic       startSec, startSolid, startDyn;

    assign startSec   = sckRise && (bitCnt == BITS_OPCODE - 6'd1)
                        && (next_opcode == OP_READ_SECURITY); // R1
    assign startSolid = sckRise && (bitCnt == BITS_ADDR - 6'd1)
                        && (opcode == OP_SOLID_READ);
    assign startDyn   = sckRise && (bitCnt == BITS_ADDR - 6'd1)
                        && (opcode == OP_DYNAMIC_READ) && protection_scheme_select; // R14

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            txByte      <= 8'h00;
            txBit       <= 3'd7;
            txOn        <= 1'b0;
            txRefresh   <= 1'b0;
            serialOut   <= 1'b0;
            serialOutEn <= 1'b0;
        end else if (csS2) begin
            txOn        <= 1'b0;
            txBit       <= 3'd7;
            serialOutEn <= 1'b0;
        end else if (startSec) begin
            txByte    <= secReg; // R2
            txBit     <= 3'd7;
            txOn      <= 1'b1;
            txRefresh <= 1'b1;
        end else if (startSolid || startDyn) begin
            if (startSolid ? solidBits[unitIndex(next_addr)]
                           : dynamicBits[unitIndex(next_addr)]) begin
                txByte <= BYTE_PROTECTED; // R20
            end else begin
                txByte <= BYTE_UNPROTECTED; // R20
            end
            txBit     <= 3'd7;
            txOn      <= 1'b1;
            txRefresh <= 1'b0;
        end else if (sckFall && txOn) begin
            serialOut   <= txByte[txBit]; // R25
            serialOutEn <= 1'b1;
            txBit       <= txBit - 3'd1;
            if (txBit == 3'd0 && txRefresh) begin
                txByte <= secReg; // R1
            end
        end
    end

endmodule

//--- sim/fsp_security_checker.sv
module fsp_security_checker (
    input wire logic                 sys_clk,
    input wire logic                 resetn,
    input wire logic                 chipSelectN,
    input wire logic                 writeProtectN,
    input wire fsp_pkg::fsp_events_s coreEvents,
    input wire logic [3:0]           blockProtectLevel,
    input wire logic                 bpAreaHit,
    input wire logic                 serialOutEn,
    input wire logic                 protectionScheme,
    input wire logic                 otpLockdown,
    input wire logic                 queryProtected,
    input wire logic [7:0]           securityStatus
);
    timeunit 1ns;
    timeprecision 1ps;
    import fsp_pkg::*;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence wpLow;
        (protectionScheme && !writeProtectN) [*4];
    endsequence
    sequence bpOff;
        (!protectionScheme && blockProtectLevel == 4'h0) [*5];
    endsequence
    sequence bpOn;
        (!protectionScheme && blockProtectLevel != 4'h0 && bpAreaHit) [*2];
    endsequence

    chk_en_in_frame: assert property (
        $rose(serialOutEn) |-> !chipSelectN)
        else $error("output enabled outside a frame");
    chk_en_release: assert property (
        $rose(chipSelectN) |-> ##[1:6] !serialOutEn)
        else $error("output still enabled after deselect");
    chk_scheme_stays: assert property (
        protectionScheme |=> protectionScheme)
        else $error("scheme select went back to zero");
    chk_lock_stays: assert property (otpLockdown |=> otpLockdown)
        else $error("lockdown bit changed after set");
    chk_status_ties: assert property (
        securityStatus[SEC_SCHEME] == protectionScheme
        && securityStatus[SEC_OTP_LOCKDOWN] == otpLockdown)
        else $error("status byte disagrees with flags");
    chk_prog_fail: assert property (
        coreEvents.progFail
        || (securityStatus[SEC_PROG_FAIL] && !coreEvents.progDone)
        |=> securityStatus[SEC_PROG_FAIL])
        else $error("program fail flag not held");
    chk_erase_fail: assert property (
        coreEvents.eraseFail
        || (securityStatus[SEC_ERASE_FAIL] && !coreEvents.eraseDone)
        |=> securityStatus[SEC_ERASE_FAIL])
        else $error("erase fail flag not held");
    chk_prog_susp: assert property (
        coreEvents.progSuspend |=> securityStatus[SEC_PROG_SUSP])
        else $error("program suspend flag not set");
    chk_prog_resume: assert property (
        coreEvents.progResume && !coreEvents.progSuspend
        |=> !securityStatus[SEC_PROG_SUSP])
        else $error("program suspend flag not cleared");
    chk_erase_susp: assert property (
        coreEvents.eraseSuspend |=> securityStatus[SEC_ERASE_SUSP])
        else $error("erase suspend flag not set");
    chk_wp_forces: assert property (wpLow |-> queryProtected)
        else $error("pin low but address unprotected");
    chk_bp_off: assert property (bpOff |-> !queryProtected)
        else $error("protected with level zero");
    chk_bp_on: assert property (bpOn |-> ##1 queryProtected)
        else $error("level area not protected");
endmodule

//--- sim/fsp_host_model.sv
module fsp_host_model (
    input  wire logic       sys_clk,
    input  wire logic       serialOut,
    input  wire logic       serialOutEn,
    output logic            chipSelectN,
    output logic            serialClk,
    output logic            serialIn,
    output logic            rxValid,
    output logic [7:0]      rxByte
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        chipSelectN = 1'b1;
        serialClk   = 1'b0;
        serialIn    = 1'b0;
        rxValid     = 1'b0;
        rxByte      = 8'h00;
    end

    task automatic half();
        repeat (4) @(negedge sys_clk);
    endtask

    // nb bits of tx msb first, then nrd bytes read back
    task automatic send(input logic [39:0] tx, input int nb, input int nrd);
        @(negedge sys_clk);
        chipSelectN = 1'b0;
        half();
        for (int i = 0; i < nb + 8 * nrd; i++) begin
            serialClk = 1'b0;
            serialIn  = (i < nb) ? tx[39-i] : ~serialIn;
            half();
            serialClk = 1'b1;
            half();
            if (i >= nb) begin
                rxByte = {rxByte[6:0], serialOutEn ? serialOut : 1'bx};
                if ((i - nb) % 8 == 7) begin
                    rxValid = 1'b1;
                    @(negedge sys_clk);
                    rxValid = 1'b0;
                end
            end
        end
        serialClk = 1'b0;
        half();
        chipSelectN = 1'b1;
        serialIn    = ~serialIn;
        repeat (8) @(negedge sys_clk);
    endtask
endmodule

//--- sim/fsp_security_tb.sv
module fsp_security_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fsp_pkg::*;

    logic              sys_clk, resetn, chipSelectN, serialClk, serialIn;
    logic              writeProtectN, factoryLockIn, overrideWrite;
    logic              overrideValue, bpAreaHit, serialOut, serialOutEn;
    logic              writeLatch, protectionScheme, otpLockdown;
    logic              queryProtected, rxValid;
    logic [3:0]        blockProtectLevel;
    logic [ADDR_W-1:0] queryAddr, ra;
    logic [7:0]        securityStatus, rxByte;
    fsp_events_s       coreEvents;
    logic [7:0]        expQ[$];
    int                n_mismatch = 0;
    int                n_checks = 0;
    int                evK[10] = '{0, 2, 5, 7, 1, 0, 1, 3, 4, 6};
    logic [7:0]        evS[10] = '{8'h05, 8'h0D, 8'h2D, 8'h6D, 8'h69,
                                   8'h6D, 8'h69, 8'h61, 8'h41, 8'h01};

    fsp_security DUT (.sys_clk, .resetn, .chipSelectN, .serialClk,
        .serialIn, .writeProtectN, .factoryLockIn, .coreEvents,
        .overrideWrite, .overrideValue, .blockProtectLevel, .bpAreaHit,
        .queryAddr, .serialOut, .serialOutEn, .writeLatch,
        .protectionScheme, .otpLockdown, .queryProtected, .securityStatus);

    fsp_host_model host (.sys_clk, .serialOut, .serialOutEn, .chipSelectN,
        .serialClk, .serialIn, .rxValid, .rxByte);

    ////////////////////////////////////////////////////////////////////
    task automatic results();
        if (n_mismatch == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic fail(input string m);
        $display("mismatch %0t %s", $time, m);
        n_mismatch++;
    endtask
    task automatic cmpBit(input logic g, input logic e, input string m);
        n_checks++;
        if (g !== e) fail(m);
    endtask
    task automatic cmpByte(input logic [7:0] g, input logic [7:0] e,
                           input string m);
        n_checks++;
        if (g !== e) fail(m);
    endtask
    // one frame; n read bytes each expected to be e
    task automatic xf(input logic [7:0] op, input logic [23:0] a,
                      input logic [7:0] d, input int nb, input int n,
                      input logic [7:0] e);
        repeat (n) expQ.push_back(e);
        host.send({op, a, d}, nb, n);
    endtask
    task automatic op8(input logic [7:0] op);
        xf(op, 24'h0, 8'h0, 8, 0, 8'h0);
    endtask
    task automatic write_latch_set_cmd();
        op8(OP_WRITE_LATCH_SET);
    endtask
    task automatic prot(input logic [23:0] a, input logic e);
        @(negedge sys_clk);
        queryAddr = a;
        repeat (4) @(negedge sys_clk);
        cmpBit(queryProtected, e, "protect state");
    endtask
    task automatic pulse(input int k);
        @(negedge sys_clk);
        coreEvents = fsp_events_s'(8'h80 >> k);
        @(negedge sys_clk);
        coreEvents = '0;
    endtask
    task automatic ovr(input logic v);
        @(negedge sys_clk);
        overrideValue = v;
        overrideWrite = 1'b1;
        @(negedge sys_clk);
        overrideWrite = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        if (rxValid === 1'b1) begin
            if (expQ.size() == 0)
                fail("unexpected byte");
            else
                cmpByte(rxByte, expQ.pop_front(), "read byte");
        end
    end

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        fail("timeout");
        results();
    end

    initial begin
        resetn            = 1'b0;
        writeProtectN     = 1'b1;
        factoryLockIn     = 1'b0;
        overrideWrite     = 1'b0;
        overrideValue     = 1'b1;
        bpAreaHit         = 1'b0;
        blockProtectLevel = 4'h0;
        queryAddr         = '0;
        coreEvents        = '0;
        void'($urandom(32'h2A08));
        repeat (8) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (6) @(negedge sys_clk);
        cmpByte(securityStatus, 8'h00, "reset status");
        factoryLockIn = 1'b1;
        xf(OP_READ_SECURITY, 24'h0, 8'h0, 8, 2, 8'h01);
        foreach (evK[j]) begin
            pulse(evK[j]);
            cmpByte(securityStatus, evS[j], "flags");
            xf(OP_READ_SECURITY, 24'h0, 8'h0, 8, 1, evS[j]);
        end
        op8(OP_WRITE_SECURITY);
        cmpBit(otpLockdown, 1'b0, "lock without latch");
        write_latch_set_cmd();
        xf(OP_WRITE_SECURITY, 24'h0, 8'h0, 9, 0, 8'h0);
        cmpBit(otpLockdown, 1'b0, "lock odd count");
        op8(OP_WRITE_SECURITY);
        cmpBit(otpLockdown, 1'b1, "lock set");
        cmpBit(writeLatch, 1'b0, "latch used");
        blockProtectLevel = 4'($urandom_range(15, 1));
        bpAreaHit = 1'b1;
        prot(24'($urandom), 1'b1);
        bpAreaHit = 1'b0;
        prot(24'($urandom), 1'b0);
        bpAreaHit = 1'b1;
        op8(OP_SCHEME_SELECT);
        cmpBit(protectionScheme, 1'b0, "scheme no latch");
        write_latch_set_cmd();
        op8(OP_ALL_UNLOCK);
        cmpBit(writeLatch, 1'b1, "sector cmd in block mode");
        op8(OP_SCHEME_SELECT);
        cmpBit(protectionScheme, 1'b1, "scheme set");
        xf(OP_READ_SECURITY, 24'h0, 8'h0, 8, 1, 8'h83);
        ra = 24'($urandom);
        prot(ra, 1'b1);
        write_latch_set_cmd();
        op8(OP_ALL_UNLOCK);
        prot(ra, 1'b0);
        writeProtectN = 1'b0;
        prot(ra, 1'b1);
        writeProtectN = 1'b1;
        write_latch_set_cmd();
        xf(DUT.OP_DYNAMIC_WRITE, 24'h001000, 8'h01, 40, 0, 8'h0);
        write_latch_set_cmd();
        xf(DUT.OP_DYNAMIC_WRITE, 24'h02F000, 8'h01, 40, 0, 8'h0);
        prot(24'h001000, 1'b1);
        prot(24'h000FFF, 1'b0);
        prot(24'h020000, 1'b1);
        prot(24'h030000, 1'b0);
        xf(OP_DYNAMIC_READ, 24'h001000, 8'h0, 32, 1, BYTE_PROTECTED);
        xf(OP_DYNAMIC_READ, 24'h002000, 8'h0, 32, 1, BYTE_UNPROTECTED);
        write_latch_set_cmd();
        xf(DUT.OP_SOLID_PROGRAM, 24'h050000, 8'h0, 32, 0, 8'h0);
        prot(24'h050000, 1'b1);
        prot(24'h060000, 1'b0);
        xf(OP_SOLID_READ, 24'h050000, 8'h0, 32, 1, BYTE_PROTECTED);
        xf(OP_SOLID_READ, 24'h060000, 8'h0, 32, 1, BYTE_UNPROTECTED);
        ovr(1'b0);
        prot(24'h050000, 1'b0);
        prot(24'h020000, 1'b1);
        ovr(1'b1);
        prot(24'h050000, 1'b1);
        op8(DUT.OP_SOLID_ERASE);
        prot(24'h050000, 1'b1);
        write_latch_set_cmd();
        op8(DUT.OP_SOLID_ERASE);
        prot(24'h050000, 1'b0);
        write_latch_set_cmd();
        op8(OP_ALL_LOCK);
        prot(24'h060000, 1'b1);
        cmpBit(expQ.size() == 0, 1'b1, "bytes missing");
        results();
    end
endmodule

bind fsp_security fsp_security_checker chk (.sys_clk, .resetn,
    .chipSelectN, .writeProtectN, .coreEvents, .blockProtectLevel,
    .bpAreaHit, .serialOutEn, .protectionScheme, .otpLockdown,
    .queryProtected, .securityStatus);
